/* File: src/ied_defs.svh */
// Offsets, field positions, reset values and timing counts of the interrupt dispatcher.
`ifndef IED_DEFS_SVH
`define IED_DEFS_SVH
`define IED_IDX_EN_A    10'h0A8
`define IED_IDX_EN_B    10'h0B8
`define IED_IDX_EN_C    10'h09A
`define IED_IDX_FLAGS   10'h000
`define IED_IDX_EVST    10'h001
`define IED_IDX_EVMSK   10'h002
`define IED_IDX_INSVC   10'h003
`define IED_GIE_BIT     7
`define IED_EN_A_WMASK  8'hBF
`define IED_EN_BC_WMASK 8'h3F
`define IED_EN_RST      8'h00
`define IED_EV_RST      2'h0
`define IED_NSRC        18
`define IED_AUTOCLR     18'h01E0F
`define IED_VEC_BASE    8'h03
`define IED_DETECT_CYC  1
`define IED_CALL_CYC    3'h6
`define IED_RESP_OKAY   2'h0
`define IED_RESP_SLVERR 2'h2
`endif

/* File: src/ied_pkg.sv */
// Types shared by the interrupt dispatcher.
`default_nettype none
package ied_pkg;
    typedef enum logic [1:0] {IED_IDLE, IED_DETECT, IED_CALL} ied_state_t;
    typedef struct packed {
        logic boundary;
        logic return_from_irq;
    } ied_cpu_t;
    typedef struct packed {
        logic       active;
        logic [7:0] vector;
    } ied_call_t;
endpackage
`default_nettype wire

/* File: src/ied_top.sv */
// Interrupt enable and dispatch block with an AXI4-Lite register slave.
// Summary of operation
// - Global enable bit 7 gates every acknowledge
// - Group A enables six sources, bits 5..0
// - Group B enables six sources, bits 5..0
// - Group C enables six sources, bits 5..0
// - Events set flags regardless of enables
// - Enabled flag acknowledged next boundary by call
// - Only strictly higher priority preempts a service
// - Lower or equal requests stay pending
// - Return ends current service, resumes caller
// - One detect cycle plus six call cycles
// - Vectors 03h upward, eight bytes apart
// - Some flags clear automatically on vectoring
`timescale 1ns/1ps
`default_nettype none
`include "ied_defs.svh"
module ied_top (
    // Clock and reset.
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // AXI4-Lite write channels.
    input  wire logic [11:0]        s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    // AXI4-Lite read channels.
    input  wire logic [11:0]        s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // Peripheral request pulses and CPU handshake.
    input  wire logic [17:0]        src_event,
    input  wire ied_pkg::ied_cpu_t  cpu_in,
    output var  ied_pkg::ied_call_t call_out,
    // Event interrupt line.
    output logic                    irq
);
    import ied_pkg::*;

    logic        awr_q, awr_d, wr_q, wr_d, bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
    logic        awh_q, awh_d, wh_q, wh_d, irq_q, irq_d;
    logic [9:0]  awi_q, awi_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [3:0]  ws_q, ws_d;
    logic [1:0]  br_q, br_d, rr_q, rr_d, evst_q, evst_d, evm_q, evm_d;
    logic [7:0]  ena_q, ena_d, enb_q, enb_d, enc_q, enc_d;
    logic [17:0] flag_q, flag_d, insvc_q, insvc_d;
    ied_state_t  st_q, st_d;
    logic [4:0]  sel_q, sel_d;
    logic [2:0]  cnt_q, cnt_d;
    ied_call_t   call_q, call_d;
    logic [17:0] en18, pend, clr_hw;
    logic        found, ack_ev, ret_ev, do_wr;
    logic [4:0]  idx;
    logic [31:0] bmask;

    // Per-source enables in source-number order.
    assign en18 = {enc_q[5], enc_q[0], enc_q[4], enc_q[3], enb_q[5:0],
                   enc_q[2], enc_q[1], ena_q[5:0]};
    assign pend = flag_q & en18 & {`IED_NSRC{ena_q[`IED_GIE_BIT]}};
    assign do_wr = awh_q & wh_q & ~bv_q;
    assign bmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};

    // Pick the lowest-numbered pending source that outranks every active service.
    always_comb begin
        found = 1'b0;
        idx = 5'h00;
        for (int i = `IED_NSRC - 1; i >= 0; i--) begin
            if (pend[i] && ((insvc_q & ((18'h2 << i) - 18'h1)) == 18'h0)) begin
                found = 1'b1;
                idx = 5'(i);
            end
        end
    end

    // Dispatch sequencer next state.
    always_comb begin
        st_d = st_q;
        sel_d = sel_q;
        cnt_d = cnt_q;
        call_d = call_q;
        insvc_d = insvc_q;
        clr_hw = 18'h0;
        ack_ev = 1'b0;
        ret_ev = 1'b0;
        if (cpu_in.return_from_irq && insvc_q != 18'h0) begin
            insvc_d = insvc_q & (insvc_q - 18'h1);
            ret_ev = 1'b1;
        end
        unique case (st_q)
            IED_IDLE: begin
                if (cpu_in.boundary && found) begin
                    st_d = IED_DETECT;
                    sel_d = idx;
                end
            end
            IED_DETECT: begin
                st_d = IED_CALL;
                cnt_d = `IED_CALL_CYC - 3'h1;
                call_d.active = 1'b1;
                call_d.vector = `IED_VEC_BASE + {sel_q, 3'b000};
                clr_hw = `IED_AUTOCLR & (18'h1 << sel_q);
                insvc_d = insvc_d | (18'h1 << sel_q);
                ack_ev = 1'b1;
            end
            IED_CALL: begin
                if (cnt_q == 3'h0) begin
                    st_d = IED_IDLE;
                    call_d.active = 1'b0;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            // The fourth state code is unreachable; fall back to idle.
            default: st_d = IED_IDLE;
        endcase
    end

    // Bus slave and register file next state; hardware sets win over clears.
    always_comb begin
        awr_d = awr_q;
        wr_d = wr_q;
        awh_d = awh_q;
        wh_d = wh_q;
        awi_d = awi_q;
        wd_d = wd_q;
        ws_d = ws_q;
        bv_d = bv_q & ~s_axi_bready;
        br_d = br_q;
        ena_d = ena_q;
        enb_d = enb_q;
        enc_d = enc_q;
        evm_d = evm_q;
        flag_d = flag_q & ~clr_hw;
        evst_d = evst_q;
        if (s_axi_awvalid && awr_q) begin
            awh_d = 1'b1;
            awi_d = s_axi_awaddr[11:2];
        end
        if (s_axi_wvalid && wr_q) begin
            wh_d = 1'b1;
            wd_d = s_axi_wdata;
            ws_d = s_axi_wstrb;
        end
        if (do_wr) begin
            awh_d = 1'b0;
            wh_d = 1'b0;
            bv_d = 1'b1;
            br_d = `IED_RESP_OKAY;
            unique case (awi_q)
                `IED_IDX_EN_A: if (ws_q[0]) ena_d = wd_q[7:0] & `IED_EN_A_WMASK;
                `IED_IDX_EN_B: if (ws_q[0]) enb_d = wd_q[7:0] & `IED_EN_BC_WMASK;
                `IED_IDX_EN_C: if (ws_q[0]) enc_d = wd_q[7:0] & `IED_EN_BC_WMASK;
                `IED_IDX_FLAGS: flag_d = flag_d & ~(wd_q[17:0] & bmask[17:0]);
                `IED_IDX_EVST: if (ws_q[0]) evst_d = evst_q & ~wd_q[1:0];
                `IED_IDX_EVMSK: if (ws_q[0]) evm_d = wd_q[1:0];
                `IED_IDX_INSVC: br_d = `IED_RESP_OKAY;
                default: br_d = `IED_RESP_SLVERR;
            endcase
        end
        flag_d = flag_d | src_event;
        evst_d = evst_d | {ret_ev, ack_ev};
        awr_d = ~awh_d & ~bv_d;
        wr_d = ~wh_d & ~bv_d;
        irq_d = |(evst_d & evm_d);
    end

    // Read channel next state.
    always_comb begin
        rv_d = rv_q & ~s_axi_rready;
        rd_d = rd_q;
        rr_d = rr_q;
        if (s_axi_arvalid && arr_q) begin
            rv_d = 1'b1;
            rr_d = `IED_RESP_OKAY;
            unique case (s_axi_araddr[11:2])
                `IED_IDX_EN_A: rd_d = {24'h0, ena_q};
                `IED_IDX_EN_B: rd_d = {24'h0, enb_q};
                `IED_IDX_EN_C: rd_d = {24'h0, enc_q};
                `IED_IDX_FLAGS: rd_d = {14'h0, flag_q};
                `IED_IDX_EVST: rd_d = {30'h0, evst_q};
                `IED_IDX_EVMSK: rd_d = {30'h0, evm_q};
                `IED_IDX_INSVC: rd_d = {14'h0, insvc_q};
                default: begin
                    rd_d = 32'h0;
                    rr_d = `IED_RESP_SLVERR;
                end
            endcase
        end
        arr_d = ~rv_d;
    end

    // State registers with synchronous reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awr_q <= 1'b0;
            wr_q <= 1'b0;
            awh_q <= 1'b0;
            wh_q <= 1'b0;
            awi_q <= 10'h000;
            wd_q <= 32'h0;
            ws_q <= 4'h0;
            bv_q <= 1'b0;
            br_q <= `IED_RESP_OKAY;
            arr_q <= 1'b0;
            rv_q <= 1'b0;
            rd_q <= 32'h0;
            rr_q <= `IED_RESP_OKAY;
            ena_q <= `IED_EN_RST;
            enb_q <= `IED_EN_RST;
            enc_q <= `IED_EN_RST;
            flag_q <= 18'h0;
            evst_q <= `IED_EV_RST;
            evm_q <= `IED_EV_RST;
            irq_q <= 1'b0;
            st_q <= IED_IDLE;
            sel_q <= 5'h00;
            cnt_q <= 3'h0;
            call_q <= '0;
            insvc_q <= 18'h0;
        end else begin
            awr_q <= awr_d;
            wr_q <= wr_d;
            awh_q <= awh_d;
            wh_q <= wh_d;
            awi_q <= awi_d;
            wd_q <= wd_d;
            ws_q <= ws_d;
            bv_q <= bv_d;
            br_q <= br_d;
            arr_q <= arr_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
            rr_q <= rr_d;
            ena_q <= ena_d;
            enb_q <= enb_d;
            enc_q <= enc_d;
            flag_q <= flag_d;
            evst_q <= evst_d;
            evm_q <= evm_d;
            irq_q <= irq_d;
            st_q <= st_d;
            sel_q <= sel_d;
            cnt_q <= cnt_d;
            call_q <= call_d;
            insvc_q <= insvc_d;
        end
    end

    // Ports come straight from their flip-flops.
    assign s_axi_awready = awr_q;
    assign s_axi_wready = wr_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = br_q;
    assign s_axi_arready = arr_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = rr_q;
    assign call_out = call_q;
    assign irq = irq_q;

    // Checks on the dispatcher.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_detect;
        st_q == IED_DETECT ##1 call_q.active;
    endsequence
    sequence s_call_six;
        call_q.active [*6] ##1 !call_q.active;
    endsequence
    sequence s_call_hold;
        st_q == IED_CALL ##1 st_q == IED_CALL;
    endsequence
    // Longer properties are named so that each label line stays short.
    property p_call_len;
        $rose(call_q.active) |-> s_call_six;
    endproperty
    property p_flag_set;
        src_event != 18'h0 |=> (flag_q & $past(src_event)) == $past(src_event);
    endproperty
    property p_auto_clr;
        st_q == IED_DETECT && !src_event[sel_q] &&
            (sel_q <= 5'h03 || (sel_q >= 5'h09 && sel_q <= 5'h0C)) |=> !flag_q[$past(sel_q)];
    endproperty
    property p_strict_pre;
        st_q == IED_DETECT |-> (insvc_q & ((18'h2 << sel_q) - 18'h1)) == 18'h0;
    endproperty
    property p_one_ack;
        st_q == IED_DETECT |=> s_call_hold;
    endproperty
    property p_return_pop;
        st_q == IED_IDLE && cpu_in.return_from_irq && insvc_q != 18'h0 |=>
            insvc_q == ($past(insvc_q) & ($past(insvc_q) - 18'h1));
    endproperty
    a_call_len: assert property (p_call_len)
        else $error("forced call not six cycles");
    a_detect_first: assert property ($rose(call_q.active) |-> $past(st_q) == IED_DETECT)
        else $error("call without detect cycle");
    a_vec_map: assert property (s_detect |-> call_q.vector == 8'h03 + {sel_q, 3'h0})
        else $error("wrong vector address");
    a_gie_block: assert property (st_q == IED_IDLE && !ena_q[7] |=> st_q == IED_IDLE)
        else $error("acknowledge with global enable off");
    a_flag_set: assert property (p_flag_set)
        else $error("event flag not set");
    a_rsvd_zero: assert property (!ena_q[6] && enb_q[7:6] == 2'h0 && enc_q[7:6] == 2'h0)
        else $error("unused enable bit set");
    a_auto_clr: assert property (p_auto_clr)
        else $error("flag not cleared on vectoring");
    a_strict_pre: assert property (p_strict_pre)
        else $error("preempted by lower priority");
    a_one_ack: assert property (p_one_ack)
        else $error("acknowledge not single");
    a_return_pop: assert property (p_return_pop)
        else $error("return did not end service");
endmodule
`default_nettype wire

/* File: tb/ied_cpu_model.sv */
// Behavioural model of the CPU core that faces the interrupt dispatcher.
`timescale 1ns/1ps
`default_nettype none
module ied_cpu_model (
    // Clock and reset.
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // Pacing and return requests from the bench.
    input  wire logic [1:0]         gap,
    input  wire logic               ret_req,
    // Handshake with the dispatcher.
    input  wire ied_pkg::ied_call_t call_in,
    output var  ied_pkg::ied_cpu_t  cpu_out
);
    import ied_pkg::*;
    logic [1:0] cnt_q;
    // Boundaries come every gap+1 cycles, none after the first cycle of a forced call, so gap sets the pace.
    always_ff @(posedge aclk) begin
        if (!aresetn || call_in.active) begin
            cnt_q   <= 2'h0;
            cpu_out <= '0;
        end else begin
            cnt_q            <= (cnt_q == gap) ? 2'h0 : cnt_q + 2'h1;
            cpu_out.boundary <= (cnt_q == gap);
            cpu_out.return_from_irq <= ret_req;
        end
    end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the interrupt dispatcher.
`timescale 1ns/1ps
`default_nettype none
`include "ied_defs.svh"
module tb_top;
    import ied_pkg::*;
    localparam logic [11:0] a_flags = {`IED_IDX_FLAGS, 2'h0};
    localparam logic [11:0] a_evst  = {`IED_IDX_EVST, 2'h0};
    localparam logic [11:0] a_evmsk = {`IED_IDX_EVMSK, 2'h0};
    localparam logic [11:0] a_insvc = {`IED_IDX_INSVC, 2'h0};
    logic        aclk, aresetn, awv, wv, bready, arv, rready, ret_req;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [11:0] awa, ara;
    logic [11:0] en_addr [3];
    logic [31:0] wd, rdata, r;
    logic [1:0]  bresp, rresp, gap;
    logic [3:0]  ws;
    logic [17:0] ev;
    ied_cpu_t    cpu;
    ied_call_t   call;
    logic [33:0] exp_q [$];
    logic [7:0]  vec_q [$];
    int          fail_count = 0, cmp_count = 0, calls = 0, act_len = 0, seed, i, n;
    ied_top dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awready), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .src_event(ev),
        .cpu_in(cpu), .call_out(call), .irq(irq));
    ied_cpu_model cpu_u (.aclk(aclk), .aresetn(aresetn), .gap(gap), .ret_req(ret_req),
        .call_in(call), .cpu_out(cpu));
    // Free-running clock.
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    task check(input logic [33:0] seen, input logic [33:0] want);
        cmp_count++;
        if (seen !== want) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task timeout;
        fail_count++;
        tally_and_finish();
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] rs);
        int k;
        @(posedge aclk);
        exp_q.push_back({rs, 32'h0});
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge aclk);
            if (awready) awv <= 1'b0;
            if (wready) wv <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (k == 40) timeout();
    endtask
    task rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] rs);
        int k;
        @(posedge aclk);
        exp_q.push_back({rs, d});
        ara <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge aclk);
            if (arready) arv <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (k == 40) timeout();
    endtask
    task pulse(input logic [17:0] b);
        @(posedge aclk);
        ev <= b;
        @(posedge aclk);
        ev <= 18'h0;
        @(posedge aclk);
    endtask
    task ret;
        @(posedge aclk);
        ret_req <= 1'b1;
        @(posedge aclk);
        ret_req <= 1'b0;
        @(posedge aclk);
    endtask
    task expect_call(input int s);
        int k;
        int c0;
        c0 = calls;
        vec_q.push_back(8'h03 + 8'(s * 8));
        for (k = 0; k < 40 && calls == c0; k++) @(posedge aclk);
        repeat (8) @(posedge aclk);
        if (k == 40) timeout();
    endtask
    // Watcher: bus answers and forced calls are matched against the oldest note.
    always @(posedge aclk) begin
        if (bvalid && bready) check({bresp, 32'h0}, exp_q.pop_front());
        if (rvalid && rready) check({rresp, rdata}, exp_q.pop_front());
        if (call.active) act_len <= act_len + 1;
        if (call.active && act_len == 0) begin
            calls <= calls + 1;
            check(call.vector, vec_q.size() > 0 ? vec_q.pop_front() : 8'hXX);
        end
        if (!call.active && act_len != 0) begin
            check(act_len, 6);
            act_len <= 0;
        end
    end
    // Main sequence.
    initial begin
        seed = 32'h71e8;
        en_addr = '{{`IED_IDX_EN_A, 2'h0}, {`IED_IDX_EN_B, 2'h0}, {`IED_IDX_EN_C, 2'h0}};
        {aresetn, awv, wv, bready, arv, rready, ret_req, gap, ev} = '0;
        {awa, ara, wd} = '0;
        ws = 4'hF;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 3; i++) begin
            rd(en_addr[i], 32'h0, `IED_RESP_OKAY);
            r = $random(seed);
            wr(en_addr[i], r, `IED_RESP_OKAY);
            rd(en_addr[i], r & (i == 0 ? 32'hBF : 32'h3F), `IED_RESP_OKAY);
            wr(en_addr[i], 32'h0, `IED_RESP_OKAY);
        end
        ws <= 4'hE;
        wr(en_addr[1], 32'h3F, `IED_RESP_OKAY);
        ws <= 4'hF;
        rd(en_addr[1], 32'h0, `IED_RESP_OKAY);
        wr(12'h3FC, 32'hFF, `IED_RESP_SLVERR);
        rd(12'h3FC, 32'h0, `IED_RESP_SLVERR);
        $display("test registers done");
        r = $random(seed);
        pulse(r[17:0]);
        rd(a_flags, {14'h0, r[17:0]}, `IED_RESP_OKAY);
        for (i = 0; i < 3; i++) wr(en_addr[i], 32'h3F, `IED_RESP_OKAY);
        repeat (20) @(posedge aclk);
        wr(a_flags, 32'h3FFFF, `IED_RESP_OKAY);
        rd(a_flags, 32'h0, `IED_RESP_OKAY);
        $display("test flags done");
        wr(a_evmsk, 32'h1, `IED_RESP_OKAY);
        wr(en_addr[0], 32'hBF, `IED_RESP_OKAY);
        for (n = 0; n < 18; n++) begin
            pulse(18'(1) << n);
            expect_call(n);
            r = (n < 4 || (n > 8 && n < 13)) ? 32'h0 : 32'(1) << n;
            rd(a_flags, r, `IED_RESP_OKAY);
            wr(a_flags, 32'(1) << n, `IED_RESP_OKAY);
            ret();
        end
        check(irq, 1'b1);
        rd(a_evst, 32'h3, `IED_RESP_OKAY);
        wr(a_evmsk, 32'h2, `IED_RESP_OKAY);
        wr(a_evst, 32'h2, `IED_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check(irq, 1'b0);
        wr(a_evmsk, 32'h1, `IED_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check(irq, 1'b1);
        wr(a_evst, 32'h3, `IED_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check(irq, 1'b0);
        rd(a_evst, 32'h0, `IED_RESP_OKAY);
        $display("test vectors done");
        gap <= 2'h3;
        pulse(18'h24);
        expect_call(2);
        repeat (20) @(posedge aclk);
        pulse(18'h1);
        expect_call(0);
        wr(a_insvc, 32'h0, `IED_RESP_OKAY);
        rd(a_insvc, 32'h5, `IED_RESP_OKAY);
        ret();
        rd(a_insvc, 32'h4, `IED_RESP_OKAY);
        ret();
        expect_call(5);
        wr(a_flags, 32'h3FFFF, `IED_RESP_OKAY);
        ret();
        rd(a_insvc, 32'h0, `IED_RESP_OKAY);
        $display("test priority done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
